// ==== hdl/sacc_core.sv ====
// Serial converter control: select, shift clock, configuration and result
// Notes on behaviour
// - Only unipolar conversions; no bipolar or two's-complement output exists.
// - Result is 10-bit straight binary, zero is 0 V, all ones is full minus one.
// - Active only while select is low; shut down otherwise.
// - While deselected, shift clock and data input are ignored.
// - Sampling window opens when channel polarity bit is shifted in.
// - Hold and conversion start on falling clock edge after dummy bit.
// - Conversion lasts twelve shift clocks from the hold point.
// - Leading zeros ignored; first one on rising edge is the start bit.
// - Bit after start picks single-ended; next picks positive channel.
// - After two null bits, result shifts out MSB first, one per clock.
// - Raising select returns port and conversion logic, except the mode selects, to initial state.
`timescale 1ns/1ps
module sacc_core (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sel_n,
  input wire logic shift_clk,
  input wire logic data_in,
  input wire logic [9:0] sample_code,
  output logic data_out,
  output logic data_out_oe,
  output logic powered,
  output logic sample_window,
  output logic hold,
  output logic single_ended_sel,
  output logic channel_polarity_sel,
  output logic result_valid,
  input wire logic result_ready,
  output logic [9:0] result_data
);
  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [1:0] sel_sync;
  logic [1:0] clk_sync;
  logic [1:0] din_sync;
  logic clk_prev;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_sync <= 2'h3;
      clk_sync <= sacc_pkg::SYNC_ZERO;
      din_sync <= sacc_pkg::SYNC_ZERO;
      clk_prev <= 1'b0;
    end
    else
    begin
      sel_sync <= {sel_sync[0], sel_n};
      clk_sync <= {clk_sync[0], shift_clk};
      din_sync <= {din_sync[0], data_in};
      clk_prev <= clk_sync[1];
    end
  end

  logic active;
  logic rise;
  logic fall;
  logic din;
  always_comb
  begin
    active = !sel_sync[1];
    rise = active && clk_sync[1] && !clk_prev;
    fall = active && !clk_sync[1] && clk_prev;
    din = din_sync[1];
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequence state
  sacc_pkg::sacc_state_t state;
  sacc_pkg::sacc_state_t next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [9:0] shreg;
  logic [9:0] next_shreg;
  logic next_data_out;
  logic next_data_out_oe;
  logic next_sample_window;
  logic next_hold;
  logic next_single;
  logic next_polarity;
  logic drive_pend;
  logic next_drive_pend;
  logic push_valid;
  logic next_push_valid;
  logic [9:0] push_data;
  logic [9:0] next_push_data;
  logic [9:0] held_code;
  logic [9:0] next_held_code;
  logic fifo_in_ready;

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_shreg = shreg;
    next_data_out = data_out;
    next_data_out_oe = data_out_oe;
    next_sample_window = sample_window;
    next_hold = hold;
    next_single = single_ended_sel;
    next_polarity = channel_polarity_sel;
    next_drive_pend = drive_pend;
    next_push_valid = push_valid && !fifo_in_ready;
    next_push_data = push_data;
    next_held_code = held_code;
    if (!active)
    begin
      next_state = sacc_pkg::SACC_IDLE;
      next_cnt = sacc_pkg::CNT_ZERO;
      next_data_out = 1'b0;
      next_data_out_oe = 1'b0;
      next_sample_window = 1'b0;
      next_hold = 1'b0;
      next_drive_pend = 1'b0;
    end
    else
    begin
      unique case (state)
        sacc_pkg::SACC_IDLE:
          next_state = sacc_pkg::SACC_START;
        sacc_pkg::SACC_START:
          if (rise && din)
          begin
            next_state = sacc_pkg::SACC_CFG;
            next_cnt = sacc_pkg::CNT_ZERO;
          end
        sacc_pkg::SACC_CFG:
          if (rise)
          begin
            next_cnt = cnt + 4'h1;
            if (cnt == sacc_pkg::CNT_ZERO)
              next_single = din;
            if (cnt == 4'h1)
            begin
              next_polarity = din;
              next_sample_window = 1'b1;
            end
            if (cnt == sacc_pkg::CNT_CFG_LAST)
              next_drive_pend = 1'b1;
          end
          else if (fall && drive_pend)
          begin
            next_sample_window = 1'b0;
            next_hold = 1'b1;
            next_shreg = sample_code;
            next_held_code = sample_code;
            next_data_out = 1'b0;
            next_data_out_oe = 1'b1;
            next_drive_pend = 1'b0;
            next_cnt = sacc_pkg::CNT_ZERO;
            next_state = sacc_pkg::SACC_NULL;
          end
        sacc_pkg::SACC_NULL:
          if (fall)
          begin
            next_cnt = cnt + 4'h1;
            if (cnt == sacc_pkg::CNT_NULL_LAST)
            begin
              next_data_out = shreg[9];
              next_shreg = {shreg[8:0], 1'b0};
              next_cnt = sacc_pkg::CNT_ZERO;
              next_state = sacc_pkg::SACC_RESULT;
            end
          end
        sacc_pkg::SACC_RESULT:
          if (fall)
          begin
            next_cnt = cnt + 4'h1;
            if (cnt == sacc_pkg::CNT_RES_LAST)
            begin
              next_hold = 1'b0;
              next_data_out_oe = 1'b0;
              next_push_valid = 1'b1;
              next_push_data = held_code;
              next_state = sacc_pkg::SACC_DONE;
            end
            else
            begin
              next_data_out = shreg[9];
              next_shreg = {shreg[8:0], 1'b0};
            end
          end
        sacc_pkg::SACC_DONE:
          next_state = sacc_pkg::SACC_DONE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= sacc_pkg::SACC_IDLE;
      cnt <= sacc_pkg::CNT_ZERO;
      shreg <= sacc_pkg::CODE_ZERO;
      data_out <= 1'b0;
      data_out_oe <= 1'b0;
      sample_window <= 1'b0;
      hold <= 1'b0;
      single_ended_sel <= 1'b0;
      channel_polarity_sel <= 1'b0;
      drive_pend <= 1'b0;
      push_valid <= 1'b0;
      push_data <= sacc_pkg::CODE_ZERO;
      held_code <= sacc_pkg::CODE_ZERO;
      powered <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      shreg <= next_shreg;
      data_out <= next_data_out;
      data_out_oe <= next_data_out_oe;
      sample_window <= next_sample_window;
      hold <= next_hold;
      single_ended_sel <= next_single;
      channel_polarity_sel <= next_polarity;
      drive_pend <= next_drive_pend;
      push_valid <= next_push_valid;
      push_data <= next_push_data;
      held_code <= next_held_code;
      powered <= active;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Completed results
  logic fifo_out_valid;
  logic [9:0] fifo_out_data;
  logic fifo_pop;
  always_comb
  begin
    fifo_pop = fifo_out_valid && (!result_valid || result_ready);
  end

  sacc_fifo #(
    .WIDTH(sacc_pkg::FIFO_WIDTH),
    .DEPTH(sacc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .flush(1'b0),
    .in_valid(push_valid),
    .in_ready(fifo_in_ready),
    .in_data(push_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result_valid <= 1'b0;
      result_data <= sacc_pkg::CODE_ZERO;
    end
    else if (fifo_pop)
    begin
      result_valid <= 1'b1;
      result_data <= fifo_out_data;
    end
    else if (result_ready)
      result_valid <= 1'b0;
  end
endmodule

// ==== hdl/sacc_pkg.sv ====
// Constants for the serial sampling converter control block
package sacc_pkg;
  localparam int RES_BITS = 10;
  localparam int CFG_BITS = 3;
  localparam int NULL_BITS = 2;
  localparam int FIFO_WIDTH = 10;
  localparam int FIFO_DEPTH = 32;
  localparam logic [9:0] CODE_ZERO = 10'h000;
  localparam logic [9:0] CODE_FULL = 10'h3ff;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_CFG_LAST = 4'h2;
  localparam logic [3:0] CNT_NULL_LAST = 4'h1;
  localparam logic [3:0] CNT_RES_LAST = 4'h9;
  localparam logic [1:0] SYNC_ZERO = 2'h0;
  typedef enum logic [2:0] {
    SACC_IDLE,
    SACC_START,
    SACC_CFG,
    SACC_NULL,
    SACC_RESULT,
    SACC_DONE
  } sacc_state_t;
endpackage

// ==== hdl/sacc_fifo.sv ====
// Result FIFO with valid and ready on both sides
`timescale 1ns/1ps
module sacc_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic push;
  logic pop;

  always_comb
  begin
    in_ready = (wr_ptr - rd_ptr) != (AW + 1)'(DEPTH);
    out_valid = wr_ptr != rd_ptr;
    out_data = mem[rd_ptr[AW-1:0]];
    push = in_valid && in_ready && !flush;
    pop = out_valid && out_ready;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end
endmodule

// ==== verification/sacc_core_chk_sva.sv ====
// Port checker of the converter control block
`timescale 1ns/1ps
module sacc_core_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sel_n,
  input wire logic data_out,
  input wire logic data_out_oe,
  input wire logic powered,
  input wire logic sample_window,
  input wire logic hold,
  input wire logic single_ended_sel,
  input wire logic channel_polarity_sel,
  input wire logic result_valid,
  input wire logic result_ready,
  input wire logic [9:0] result_data
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_off;
    sel_n [*6];
  endsequence
  sequence s_hold_in;
    $rose(hold);
  endsequence
  property p_off;
    s_off |-> !powered;
  endproperty
  a_off: assert property (p_off) else $error("powered while deselected");
  property p_quiet;
    s_off |-> !data_out_oe;
  endproperty
  a_quiet: assert property (p_quiet) else $error("output driven while deselected");
  property p_ignore;
    s_off |-> !sample_window && !hold;
  endproperty
  a_ignore: assert property (p_ignore) else $error("activity while deselected");
  property p_wake;
    $rose(powered) |-> !sel_n && $past(!sel_n, 2);
  endproperty
  a_wake: assert property (p_wake) else $error("woke without select");
  property p_hold_after_window;
    s_hold_in |-> $past(sample_window);
  endproperty
  a_hold_after_window: assert property (p_hold_after_window) else $error("hold without window");
  property p_window_first;
    $rose(sample_window) |-> !hold && !data_out_oe;
  endproperty
  a_window_first: assert property (p_window_first) else $error("window late");
  property p_null_first;
    s_hold_in |-> ##[0:1] (data_out_oe && !data_out);
  endproperty
  a_null_first: assert property (p_null_first) else $error("no null bit");
  property p_cfg_held;
    hold |-> $stable(single_ended_sel) && $stable(channel_polarity_sel);
  endproperty
  a_cfg_held: assert property (p_cfg_held) else $error("mode moved in hold");
  property p_fifo_hold;
    result_valid && !result_ready |=> result_valid && $stable(result_data);
  endproperty
  a_fifo_hold: assert property (p_fifo_hold) else $error("result lost");
endmodule

// ==== verification/sacc_host.sv ====
// Host model driving select, shift clock and configuration
`timescale 1ns/1ps
module sacc_host (
  input wire logic sys_clk,
  output logic sel_n,
  output logic shift_clk,
  output logic data_in,
  input wire logic data_out
);
  initial
  begin
    sel_n = 1'b1;
    shift_clk = 1'b0;
    data_in = 1'b0;
  end
  // One shift clock pulse at a safe rate
  task automatic pulse(input logic d, output logic q);
    data_in = d;
    repeat (7) @(negedge sys_clk);
    shift_clk = 1'b1;
    q = data_out;
    repeat (7) @(negedge sys_clk);
    shift_clk = 1'b0;
  endtask
  // Whole exchange, n pulses after the dummy bit
  task automatic xfer(input logic [1:0] cfg, input int n, output logic [11:0] rx);
    logic q;
    rx = 12'h000;
    sel_n = 1'b0;
    pulse(1'b0, q);
    pulse(1'b1, q);
    pulse(cfg[1], q);
    pulse(cfg[0], q);
    pulse(1'b1, q);
    for (int i = 0; i < n; i++)
    begin
      pulse(i[0], q);
      rx = {rx[10:0], q};
    end
    repeat (6) @(negedge sys_clk);
    sel_n = 1'b1;
    repeat (8) @(negedge sys_clk);
  endtask
  // Toggling pins while deselected
  task automatic noise;
    repeat (20)
    begin
      @(negedge sys_clk);
      shift_clk = ~shift_clk;
      data_in = ~data_in;
    end
  endtask
endmodule

// ==== verification/sacc_core_bench.sv ====
// Self-checking bench of the converter control block
`timescale 1ns/1ps
module sacc_core_bench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [9:0] sample_code = 10'h000;
  logic result_ready = 1'b0;
  logic sel_n, shift_clk, data_in, data_out, data_out_oe, powered, sample_window, hold;
  logic single_ended_sel, channel_polarity_sel, result_valid;
  logic [9:0] result_data;
  logic [11:0] rx;
  int errors = 0;
  int n_tests = 0;
  always #5 sys_clk = ~sys_clk;
  sacc_host host_u (.sys_clk, .sel_n, .shift_clk, .data_in, .data_out);
  sacc_core dut_u (.sys_clk, .rst_n, .sel_n, .shift_clk, .data_in, .sample_code, .data_out,
    .data_out_oe, .powered, .sample_window, .hold, .single_ended_sel, .channel_polarity_sel,
    .result_valid, .result_ready, .result_data);
  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up;
    if (errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic pop(input logic [9:0] code);
    check("fifo", {2'b01, code}, {1'b0, result_valid, result_data});
    @(negedge sys_clk);
    result_ready = 1'b1;
    @(negedge sys_clk);
    result_ready = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_idle;
    host_u.noise();
    check("idle", 12'h000, {7'h00, powered, data_out_oe, sample_window, hold, result_valid});
  endtask
  task automatic t_codes;
    logic [9:0] codes [5] = '{10'h000, 10'h3ff, 10'h2aa, 10'h155, 10'h001};
    for (int k = 0; k < 5; k++)
    begin
      sample_code = codes[k];
      fork
        host_u.xfer(k[1:0], 12, rx);
        begin
          repeat (60) @(negedge sys_clk);
          check("window", 12'h002, {10'h000, sample_window, hold});
          repeat (28) @(negedge sys_clk);
          check("mode", {8'h00, 2'b01, k[1:0]}, {8'h00, sample_window, hold,
            single_ended_sel, channel_polarity_sel});
          sample_code = ~codes[k];
          repeat (146) @(negedge sys_clk);
          check("conv busy", 12'h003, {10'h000, hold, data_out_oe});
          repeat (10) @(negedge sys_clk);
          check("conv end", 12'h000, {10'h000, hold, data_out_oe});
        end
      join
      check("serial", {2'b00, codes[k]}, rx);
      pop(codes[k]);
    end
  endtask
  task automatic t_abort;
    sample_code = 10'h2a0;
    host_u.xfer(2'b10, 6, rx);
    check("abort", 12'h000, {11'h000, result_valid});
    sample_code = 10'h0f0;
    host_u.xfer(2'b11, 12, rx);
    check("after abort", 12'h0f0, rx);
    pop(10'h0f0);
  endtask
  task automatic t_fill;
    for (int i = 0; i < 32; i++)
    begin
      sample_code = 10'(i * 33);
      host_u.xfer(2'b10, 12, rx);
    end
    for (int i = 0; i < 32; i++)
      pop(10'(i * 33));
    check("empty", 12'h000, {11'h000, result_valid});
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    t_idle();
    t_codes();
    t_abort();
    t_fill();
    wrap_up();
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    wrap_up();
  end
endmodule
bind sacc_core sacc_core_chk chk_u (.sys_clk, .rst_n, .sel_n, .data_out, .data_out_oe, .powered,
  .sample_window, .hold, .single_ended_sel, .channel_polarity_sel, .result_valid,
  .result_ready, .result_data);
